// ==== mbd_mac_ctrl.v ====
// mac control register with back-off timer, duplex and speed selection
//
// Summary of operation
// - after a collision wait r slot-times, r below 2^K, K = min(retries, 10).
// - wait comes from low K bits of free-running lfsr, counted down per slot.
// - at K of ten with limit select 00 use lower ten lfsr bits.
// - at K of ten with limit select 10 use only lowest four lfsr bits.
// - one slot-time equals 512 bit times at the current line speed.
// - duplex bit 3 writable when auto duplex off, else reports detected duplex.
// - duplex set means full duplex, clear means half duplex.
// - at 1000 Mbps half duplex is disabled regardless of the duplex bit.
// - speed bits 2:1 writable when auto speed off, else report detected speed.
// - speed selects 10 or 100 over mii, or 1000 over gmii.
// - duplex and speed defaults from eeprom flags, else otp, else zero.
// - lite reset restores duplex and speed to last loaded image; bus reset clears them to zero.
// - auto duplex defaults from boot flag or otp, else one; restored on reset.
// - auto speed defaults from boot flag or otp, else zero; restored on reset.
// - duplex and speed are protected from lite reset by the protect control.
// - with auto speed, speed comes from sampling the phy receive clock.
`timescale 1ns/10ps
`include "mbd_defs.vh"
module mbd_mac_ctrl #(
   parameter CLK_MHZ = 250,
   parameter RETRY_W = 5
) (
   input wire mclk, // 250 mhz clock
   input wire reset_n, // asynchronous reset, active low
   input wire [3:0] avs_address, // word address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // byte lanes
   output wire avs_waitrequest, // stall
   output reg [31:0] avs_readdata, // read data
   input wire lite_soft_reset, // lite soft reset pulse, same clock
   input wire reset_protect, // keeps duplex and speed over lite reset
   input wire eeprom_present, // eeprom image loaded
   input wire otp_present, // otp programmed
   input wire [1:0] eeprom_speed, // eeprom speed default
   input wire eeprom_duplex, // eeprom duplex default
   input wire boot_duplex_auto_flag, // eeprom auto duplex flag
   input wire boot_speed_auto_flag, // eeprom auto speed flag
   input wire [1:0] otp_speed, // otp speed default
   input wire otp_duplex, // otp duplex default
   input wire otp_duplex_auto, // otp auto duplex
   input wire otp_speed_auto, // otp auto speed
   input wire image_load, // pulse: latch defaults from image
   input wire det_duplex_pin, // detected duplex from phy, async
   input wire [1:0] det_speed_pin, // speed from rx clock sampling, async
   input wire collision, // pulse: collision on current frame
   input wire [RETRY_W-1:0] retry_count, // retries of current frame
   output reg backoff_busy, // back-off wait in progress
   output reg backoff_done, // pulse: wait expired
   output reg full_duplex, // effective duplex mode
   output reg [1:0] speed_sel, // effective speed code
   output reg use_gmii, // gigabit interface selected
   output reg mac_logic_reset // one-cycle mac reset pulse
);

   // ==========================================================
   // state
   // live control fields
   reg [1:0] backoff_limit_sel;
   reg duplex_sel;
   reg [1:0] speed_cfg;
   reg duplex_auto;
   reg auto_speed_detect;
   reg mac_soft_reset;
   // image last loaded from eeprom or otp
   reg img_duplex;
   reg [1:0] img_speed;
   reg img_duplex_auto;
   reg img_speed_auto;
   // back-off timer
   reg [9:0] lfsr;
   reg [9:0] wait_cnt;
   reg [13:0] slot_cnt;
   // synchroniser stages
   reg dup_s1, dup_s2;
   reg [1:0] spd_s1, spd_s2;
   // bus answer
   reg rd_ack;
   reg [31:0] next_rdata;
   reg [9:0] next_wait;
   wire wr = avs_write & avs_byteenable[0];
   wire wr_ctl = wr & (avs_address == `MBD_ADDR_MAC_CONTROL);
   wire wr_bo = wr & (avs_address == `MBD_ADDR_BACKOFF);
   wire wr_hi = avs_write & avs_byteenable[1] & (avs_address == `MBD_ADDR_MAC_CONTROL);
   // reads answer from a flip-flop on the edge after they are taken, so each read
   // sees one wait state; writes still land on the edge that takes them
   wire rd_take = avs_read & ~rd_ack;
   assign avs_waitrequest = rd_take;

   // ==========================================================
   // slot lengths
   // 512 bit times in clocks; the 14-bit slot counter covers clocks up to 319 mhz
   localparam [31:0] SLOT_10_FULL = `MBD_SLOT_BITS * CLK_MHZ / `MBD_MBPS_10;
   localparam [31:0] SLOT_100_FULL = `MBD_SLOT_BITS * CLK_MHZ / `MBD_MBPS_100;
   localparam [31:0] SLOT_1000_FULL = `MBD_SLOT_BITS * CLK_MHZ / `MBD_MBPS_1000;
   localparam [13:0] SLOT_10 = SLOT_10_FULL[13:0];
   localparam [13:0] SLOT_100 = SLOT_100_FULL[13:0];
   localparam [13:0] SLOT_1000 = SLOT_1000_FULL[13:0];

   // ==========================================================
   // functions
   // cycles per slot: 512 bit times at the given speed
   function [13:0] slot_cycles;
      input [1:0] spd;
      begin
         case (spd)
            `MBD_SPEED_10: slot_cycles = SLOT_10;
            `MBD_SPEED_100: slot_cycles = SLOT_100;
            `MBD_SPEED_1000: slot_cycles = SLOT_1000;
            default: slot_cycles = SLOT_100;
         endcase
      end
   endfunction

   // mask of K low bits; K capped at ten, aggressive limit trims ten to four
   function [9:0] k_mask;
      input [RETRY_W-1:0] n;
      input [1:0] lim;
      reg [3:0] k;
      begin
         k = (n >= `MBD_K_MAX) ? `MBD_K_MAX : n[3:0];
         // a k of zero gives an empty mask, so the retry goes out at once
         if (k == `MBD_K_MAX && lim == `MBD_LIMIT_AGGR)
            k = `MBD_K_AGGR;
         k_mask = (10'h001 << k) - 10'h001;
      end
   endfunction

   // ==========================================================
   // synchronisers for detected link state
   // the detected mode follows the phy receive clock, not mclk; only the
   // second stage is read, so a half-settled first stage never reaches logic
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dup_s1 <= 1'b0;
         dup_s2 <= 1'b0;
         spd_s1 <= 2'h0;
         spd_s2 <= 2'h0;
      end else begin
         dup_s1 <= det_duplex_pin;
         dup_s2 <= dup_s1;
         spd_s1 <= det_speed_pin;
         spd_s2 <= spd_s1;
      end
   end

   // ==========================================================
   // boot image capture
   // the image is kept apart from the live fields so a lite reset can restore it
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         img_duplex <= `MBD_FIELD_RESET;
         img_speed <= `MBD_SPEED_10;
         img_duplex_auto <= `MBD_DUPLEX_AUTO_RESET;
         img_speed_auto <= `MBD_SPEED_AUTO_RESET;
      end else if (image_load) begin
         if (eeprom_present) begin
            img_duplex <= eeprom_duplex;
            img_speed <= eeprom_speed;
            img_duplex_auto <= boot_duplex_auto_flag;
            img_speed_auto <= boot_speed_auto_flag;
         end else if (otp_present) begin
            img_duplex <= otp_duplex;
            img_speed <= otp_speed;
            img_duplex_auto <= otp_duplex_auto;
            img_speed_auto <= otp_speed_auto;
         end else begin
            img_duplex <= `MBD_FIELD_RESET;
            img_speed <= `MBD_SPEED_10;
            img_duplex_auto <= `MBD_DUPLEX_AUTO_RESET;
            img_speed_auto <= `MBD_SPEED_AUTO_RESET;
         end
      end
   end

   // ==========================================================
   // control register
   // a soft reset written here clears itself on the next edge; the mac sees
   // it one edge later as a single-cycle pulse
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         backoff_limit_sel <= `MBD_LIMIT_RESET;
         duplex_sel <= `MBD_FIELD_RESET;
         speed_cfg <= `MBD_SPEED_10;
         duplex_auto <= `MBD_DUPLEX_AUTO_RESET;
         auto_speed_detect <= `MBD_SPEED_AUTO_RESET;
         mac_soft_reset <= 1'b0;
      end else if (lite_soft_reset) begin
         // auto bits always return to the image; protection covers duplex and speed only
         backoff_limit_sel <= `MBD_LIMIT_RESET;
         duplex_auto <= img_duplex_auto;
         auto_speed_detect <= img_speed_auto;
         mac_soft_reset <= 1'b0;
         if (!reset_protect) begin
            duplex_sel <= img_duplex;
            speed_cfg <= img_speed;
         end
      end else if (image_load) begin
         // an image load sets the live fields straight from the new image
         duplex_sel <= eeprom_present ? eeprom_duplex : (otp_present ? otp_duplex : 1'b0);
         speed_cfg <= eeprom_present ? eeprom_speed : (otp_present ? otp_speed : 2'h0);
         duplex_auto <= eeprom_present ? boot_duplex_auto_flag :
            (otp_present ? otp_duplex_auto : `MBD_DUPLEX_AUTO_RESET);
         auto_speed_detect <= eeprom_present ? boot_speed_auto_flag :
            (otp_present ? otp_speed_auto : `MBD_SPEED_AUTO_RESET);
      end else begin
         mac_soft_reset <= wr_ctl & avs_writedata[`MBD_POS_SOFT_RESET];
         if (wr_ctl)
            backoff_limit_sel <= avs_writedata[`MBD_POS_BOLIM_LO+1:`MBD_POS_BOLIM_LO];
         if (wr_hi) begin
            duplex_auto <= avs_writedata[`MBD_POS_DUPLEX_AUTO];
            auto_speed_detect <= avs_writedata[`MBD_POS_SPEED_AUTO];
         end
         // detected values overwrite the fields on every edge while auto is on
         if (duplex_auto)
            duplex_sel <= dup_s2;
         else if (wr_ctl)
            duplex_sel <= avs_writedata[`MBD_POS_DUPLEX];
         if (auto_speed_detect)
            speed_cfg <= spd_s2;
         else if (wr_ctl)
            speed_cfg <= avs_writedata[`MBD_POS_SPEED_LO+1:`MBD_POS_SPEED_LO];
      end
   end

   // ==========================================================
   // effective mode outputs
   // outputs trail the control fields by one edge so they leave flip-flops
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         full_duplex <= 1'b0;
         speed_sel <= `MBD_SPEED_10;
         use_gmii <= 1'b0;
         mac_logic_reset <= 1'b0;
      end else begin
         // reserved code runs as 100 mbps mii
         speed_sel <= (speed_cfg == `MBD_SPEED_RSVD) ? `MBD_SPEED_100 : speed_cfg;
         use_gmii <= (speed_cfg == `MBD_SPEED_1000);
         full_duplex <= duplex_sel | (speed_cfg == `MBD_SPEED_1000);
         mac_logic_reset <= mac_soft_reset;
      end
   end

   // ==========================================================
   // back-off timer
   // the lfsr runs on every edge, so the draw depends on when the collision falls
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         lfsr <= `MBD_LFSR_SEED;
      else
         lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
   end

   always @* begin
      next_wait = lfsr & k_mask(retry_count, backoff_limit_sel);
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wait_cnt <= 10'h000;
         slot_cnt <= 14'h0000;
         backoff_busy <= 1'b0;
         backoff_done <= 1'b0;
      end else begin
         backoff_done <= 1'b0;
         // an abort drops the wait with no done pulse; a zero draw ends at once
         if (mac_logic_reset || wr_bo) begin
            backoff_busy <= 1'b0;
         end else if (collision && !full_duplex) begin
            wait_cnt <= next_wait;
            slot_cnt <= slot_cycles(speed_sel) - 14'h0001;
            backoff_busy <= (next_wait != 10'h000);
            backoff_done <= (next_wait == 10'h000);
         end else if (backoff_busy) begin
            if (slot_cnt == 14'h0000) begin
               slot_cnt <= slot_cycles(speed_sel) - 14'h0001;
               wait_cnt <= wait_cnt - 10'h001;
               if (wait_cnt == 10'h001) begin
                  backoff_busy <= 1'b0;
                  backoff_done <= 1'b1;
               end
            end else begin
               slot_cnt <= slot_cnt - 14'h0001;
            end
         end
      end
   end

   // ==========================================================
   // read mux
   always @* begin
      next_rdata = 32'h00000000;
      case (avs_address)
         `MBD_ADDR_MAC_CONTROL: begin
            next_rdata[`MBD_POS_SOFT_RESET] = mac_soft_reset;
            next_rdata[`MBD_POS_SPEED_LO+1:`MBD_POS_SPEED_LO] = speed_cfg;
            next_rdata[`MBD_POS_DUPLEX] = duplex_sel;
            next_rdata[`MBD_POS_BOLIM_LO+1:`MBD_POS_BOLIM_LO] = backoff_limit_sel;
            next_rdata[`MBD_POS_DUPLEX_AUTO] = duplex_auto;
            next_rdata[`MBD_POS_SPEED_AUTO] = auto_speed_detect;
         end
         `MBD_ADDR_BOOT_IMAGE:
            next_rdata[5:0] = {img_speed_auto, img_duplex_auto, img_speed, img_duplex, 1'b0};
         `MBD_ADDR_BACKOFF:
            next_rdata[10:0] = {backoff_busy, wait_cnt};
         `MBD_ADDR_STATUS:
            next_rdata[3:0] = {use_gmii, speed_sel, full_duplex};
         // unmapped words read as zero
         default: next_rdata = 32'h00000000;
      endcase
   end

   // ==========================================================
   // read data register
   // the data stay after the read ends; the master takes them on the edge
   // at which it sees waitrequest low
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ack <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         rd_ack <= rd_take;
         if (rd_take)
            avs_readdata <= next_rdata;
      end
   end
endmodule // mbd_mac_ctrl

// ==== mbd_defs.vh ====
// register map, field positions, reset values and timing constants for the mac control block
`ifndef MBD_DEFS_VH
`define MBD_DEFS_VH
`define MBD_ADDR_MAC_CONTROL 4'h0
`define MBD_ADDR_BOOT_IMAGE 4'h1
`define MBD_ADDR_BACKOFF 4'h2
`define MBD_ADDR_STATUS 4'h3
`define MBD_POS_SOFT_RESET 0
`define MBD_POS_SPEED_LO 1
`define MBD_POS_DUPLEX 3
`define MBD_POS_BOLIM_LO 6
`define MBD_POS_DUPLEX_AUTO 11
`define MBD_POS_SPEED_AUTO 12
`define MBD_SPEED_10 2'h0
`define MBD_SPEED_100 2'h1
`define MBD_SPEED_1000 2'h2
`define MBD_SPEED_RSVD 2'h3
`define MBD_LIMIT_RESET 2'h0
`define MBD_LIMIT_RELAXED 2'h0
`define MBD_LIMIT_AGGR 2'h2
`define MBD_DUPLEX_AUTO_RESET 1'h1
`define MBD_SPEED_AUTO_RESET 1'h0
`define MBD_FIELD_RESET 1'h0
`define MBD_K_MAX 4'hA
`define MBD_K_AGGR 4'h4
`define MBD_SLOT_BITS 32'h00000200
`define MBD_MBPS_10 32'h0000000A
`define MBD_MBPS_100 32'h00000064
`define MBD_MBPS_1000 32'h000003E8
`define MBD_LFSR_SEED 10'h3FF
`endif

// ==== mbd_mac_ctrl_properties.sv ====
// checker of the mac control block ports
`timescale 1ns/10ps
module mbd_ctrl_props (
   input wire mclk, // clock
   input wire reset_n, // reset
   input wire [3:0] avs_address, // addr
   input wire avs_read, // rd
   input wire avs_write, // wr
   input wire [31:0] avs_writedata, // wdata
   input wire [3:0] avs_byteenable, // lanes
   input wire [31:0] avs_readdata, // rdata
   input wire avs_waitrequest, // stall
   input wire lite_soft_reset, // lite
   input wire collision, // col
   input wire backoff_busy, // busy
   input wire backoff_done, // done
   input wire full_duplex, // fdx
   input wire [1:0] speed_sel, // speed
   input wire use_gmii, // gmii
   input wire mac_logic_reset // mac reset pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   reg [31:0] busy_len;
   // ====
   // helpers
   // longest legal wait is 1023 slots of 12800 clocks
   always @(posedge mclk or negedge reset_n)
      if (!reset_n) busy_len <= 32'h0;
      else busy_len <= backoff_busy ? busy_len + 32'h1 : 32'h0;
   sequence s_rst_wr;
      avs_write && avs_address == 4'h0 && avs_byteenable[0] && avs_writedata[0];
   endsequence
   sequence s_rst_pulse;
      ##2 mac_logic_reset ##1 !mac_logic_reset;
   endsequence
   sequence s_col;
      collision && !avs_write && !lite_soft_reset && !mac_logic_reset;
   endsequence
   // ====
   // properties
   a_rst_pulse: assert property (s_rst_wr |-> s_rst_pulse)
      else $error("mac reset pulse wrong");
   a_gig_full: assert property (speed_sel == 2'h2 |-> full_duplex)
      else $error("half duplex at gigabit");
   a_gmii_sel: assert property (use_gmii == (speed_sel == 2'h2))
      else $error("interface select wrong");
   a_no_rsvd: assert property (speed_sel != 2'h3)
      else $error("reserved speed code");
   a_done_pulse: assert property (backoff_done |=> !backoff_done)
      else $error("done longer than a cycle");
   a_fdx_ignore: assert property ((s_col ##0 full_duplex && !backoff_busy) |=> !backoff_busy)
      else $error("back-off in full duplex");
   a_hdx_start: assert property ((s_col ##0 !full_duplex) |=> backoff_busy || backoff_done)
      else $error("collision not taken");
   a_busy_bound: assert property (busy_len <= 32'h00C7CE02)
      else $error("back-off too long");
   a_unmapped_rd: assert property (avs_read && !avs_waitrequest && avs_address > 4'h3
      |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // mbd_ctrl_props
bind mbd_mac_ctrl mbd_ctrl_props chk (.mclk, .reset_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .lite_soft_reset,
   .collision,
   .backoff_busy, .backoff_done, .full_duplex, .speed_sel, .use_gmii, .mac_logic_reset);

// ==== mbd_phy_model.sv ====
// phy-side model presenting detected duplex and speed
`timescale 1ns/10ps
module mbd_phy_model (
   input wire mclk, // clock
   input wire link_duplex, // negotiated duplex
   input wire [1:0] link_speed, // line speed
   output reg det_duplex_pin = 1'b0, // detected duplex
   output reg [1:0] det_speed_pin = 2'h0 // rx clock speed
);
   reg [2:0] stage = 3'h0;
   // ====
   // detection lags the link, as a sampler would
   always @(posedge mclk) begin
      stage <= {link_duplex, link_speed};
      {det_duplex_pin, det_speed_pin} <= stage;
   end
endmodule // mbd_phy_model

// ==== tb_mac_backoff_duplex_speed_ctrl.sv ====
// self-checking bench of the mac control block
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done = checks_done + 1; if ((g) !== (e)) begin \
   n_fail = n_fail + 1; $display("wrong value at %0t: got %h", $time, g); end end
module tb_mac_backoff_duplex_speed_ctrl;
   reg mclk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, lite = 1'b0, prot = 1'b0;
   reg ldi = 1'b0, col = 1'b0, wdup = 1'b0, seen = 1'b0;
   reg [1:0] wspd = 2'h0, sp = 2'h0;
   reg [3:0] adr = 4'h0, be = 4'hF;
   reg [4:0] rty = 5'h0;
   reg [11:0] img = 12'h0;
   reg [31:0] wd = 32'h0, rnd = 32'h016696B6, q, d;
   wire wreq, bbusy, bdone, fdx, gm, mlr, ddet;
   wire [1:0] spd, sdet;
   wire [31:0] rdata;
   integer n_fail = 0, checks_done = 0, i, n;
   always #2 mclk = ~mclk;
   always @(negedge mclk) if (mlr === 1'b1) seen = 1'b1;
   mbd_phy_model phy (.mclk(mclk), .link_duplex(wdup), .link_speed(wspd),
      .det_duplex_pin(ddet), .det_speed_pin(sdet));
   mbd_mac_ctrl dut (.mclk(mclk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_waitrequest(wreq),
      .avs_readdata(rdata), .lite_soft_reset(lite), .reset_protect(prot),
      .eeprom_present(img[11]), .otp_present(img[10]), .eeprom_speed(img[9:8]),
      .eeprom_duplex(img[7]), .boot_duplex_auto_flag(img[6]), .boot_speed_auto_flag(img[5]),
      .otp_speed(img[4:3]), .otp_duplex(img[2]), .otp_duplex_auto(img[1]),
      .otp_speed_auto(img[0]), .image_load(ldi), .det_duplex_pin(ddet),
      .det_speed_pin(sdet), .collision(col), .retry_count(rty), .backoff_busy(bbusy),
      .backoff_done(bdone), .full_duplex(fdx), .speed_sel(spd), .use_gmii(gm),
      .mac_logic_reset(mlr));
   // ====
   // helpers
   function [31:0] nxt(input [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // one bus cycle; an idle edge follows so no strobe is set twice in one step
   task xfer(input w, input [3:0] a, input [31:0] v);
      begin
         adr <= a;
         wd <= v;
         if (w) wr <= 1'b1; else rd <= 1'b1;
         @(posedge mclk);
         while (wreq !== 1'b0) @(posedge mclk);
         q = rdata;
         wr <= 1'b0;
         rd <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task reload(input [11:0] v, input by_lite, input [31:0] e);
      begin
         img <= v;
         if (by_lite) lite <= 1'b1; else ldi <= 1'b1;
         @(posedge mclk);
         lite <= 1'b0;
         ldi <= 1'b0;
         repeat (4) @(posedge mclk);
         xfer(1'b0, 4'h0, 32'h0);
         `CHK(q, e)
      end
   endtask
   // wait length must be a whole number of slots below 2^k slots
   task bo(input [4:0] r, input [31:0] slot, input [31:0] k);
      begin
         rty <= r;
         col <= 1'b1;
         @(posedge mclk);
         col <= 1'b0;
         n = 0;
         @(posedge mclk);
         while (bbusy === 1'b1 && n < 20000) begin
            n = n + 1;
            @(posedge mclk);
         end
         if (bdone !== 1'b1) @(posedge mclk);
         `CHK(bdone, 1'b1)
         `CHK(n <= ((1 << k) - 1) * slot + 2, 1'b1)
         `CHK((n + 2) % slot <= 4, 1'b1)
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (90000) @(posedge mclk);
      n_fail = n_fail + 1;
      results;
   end
   // ====
   // tests
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      xfer(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h00000800)
      xfer(1'b1, 4'h9, 32'hFFFFFFFF);
      xfer(1'b0, 4'h9, 32'h0);
      `CHK(q, 32'h0)
      wdup <= 1'b1;
      wspd <= 2'h1;
      xfer(1'b1, 4'h0, 32'h00001800);
      repeat (6) @(posedge mclk);
      xfer(1'b1, 4'h0, 32'h00001804);
      xfer(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h0000180A)
      $display("end of defaults and detection");
      xfer(1'b1, 4'h0, 32'h0);
      for (i = 0; i < 9; i = i + 1) begin
         rnd = nxt(rnd);
         d = rnd & 32'h000000C8;
         d[2:1] = sp;
         sp = (sp == 2'h2) ? 2'h0 : sp + 2'h1;
         xfer(1'b1, 4'h0, d);
         xfer(1'b0, 4'h0, 32'h0);
         `CHK(q, d)
         `CHK(spd, d[2:1])
         `CHK(fdx, d[3] | d[2])
         `CHK(gm, d[2])
      end
      xfer(1'b1, 4'h0, 32'h00000006);
      @(posedge mclk);
      `CHK(spd, 2'h1)
      $display("end of manual mode");
      xfer(1'b1, 4'h0, 32'h00000002);
      bo(5'h0, 1280, 0);
      bo(5'h3, 1280, 3);
      xfer(1'b1, 4'h0, 32'h00000082);
      bo(5'hC, 1280, 4);
      xfer(1'b1, 4'h0, 32'h0);
      bo(5'h1, 12800, 1);
      xfer(1'b1, 4'h0, 32'h00000004);
      col <= 1'b1;
      @(posedge mclk);
      col <= 1'b0;
      @(posedge mclk);
      `CHK({bbusy, bdone}, 2'h0)
      xfer(1'b1, 4'h0, 32'h00000001);
      repeat (4) @(posedge mclk);
      `CHK(seen, 1'b1)
      xfer(1'b0, 4'h0, 32'h0);
      `CHK(q[0], 1'b0)
      $display("end of back-off and soft reset");
      wdup <= 1'b0;
      reload(12'hD93, 1'b0, 32'h0000000A);
      reload(12'h195, 1'b0, 32'h00000800);
      reload(12'h590, 1'b0, 32'h00000004);
      xfer(1'b1, 4'h0, 32'h00000002);
      reload(12'h590, 1'b1, 32'h00000004);
      prot <= 1'b1;
      xfer(1'b1, 4'h0, 32'h00000002);
      reload(12'h590, 1'b1, 32'h00000002);
      $display("end of image load");
      results;
   end
endmodule // tb_mac_backoff_duplex_speed_ctrl
